/* rtl/rsfe_top.sv */
// module: raw serial frame engine, receive and send of unframed byte streams
`timescale 1ns/1ps
module rsfe_top (
	input  wire logic        ref_clk,
	input  wire logic        srst,
	input  wire logic [11:0] bus_addr,
	input  wire logic [31:0] bus_wdata,
	input  wire logic        bus_wr,
	input  wire logic        bus_rd,
	output logic      [31:0] bus_rdata,
	output logic             irq,
	input  wire logic        rx_valid_0,
	input  wire logic [7:0]  rx_data_0,
	input  wire logic        rx_valid_1,
	input  wire logic [7:0]  rx_data_1,
	output logic             tx_valid,
	output logic      [7:0]  tx_data,
	output logic             tx_chan,
	input  wire logic        tx_ready
);
	rsfe_pkg::rsfe_state_e  rx_state_reg;
	rsfe_pkg::rsfe_state_e  tx_state_reg;
	logic [7:0]  rx_mem [rsfe_pkg::DEPTH];
	logic [7:0]  tx_mem [rsfe_pkg::DEPTH];
	logic [15:0] rx_ctrl_reg, rx_fmt_reg, tx_ctrl_reg, tx_len_reg, rx_job_fmt_reg;
	logic [8:0]  rx_size_reg, tx_size_reg, rx_cnt_reg, rx_len_reg, tx_idx_reg, tx_last_reg;
	logic [8:0]  rx_cnt_inc;
	logic [7:0]  rx_code_reg, tx_code_reg, rx_in_data, rx_byte, rx_ch_sel, rx_lim;
	logic [7:0]  tx_ch_sel, tx_cur, tx_char;
	logic [3:0]  irq_stat_reg, irq_mask_reg, rx_nib_reg, ev;
	logic        rx_req_d_reg, rx_job_ch_reg, rx_job_asc_reg, rx_done_reg, rx_err_reg;
	logic        rx_half_reg, tx_req_d_reg, tx_done_reg, tx_err_reg, tx_half_reg, tx_asc_reg;
	logic        rx_err_d_reg, tx_err_d_reg;
	logic        rx_edge, tx_edge, rx_in_valid, rx_byte_ok, rx_fin, rx_ovf, tx_take, tx_fin, wr_hit;
	default clocking chk_clk @(posedge ref_clk); endclocking
	default disable iff (srst);

	// hex digit to ascii character and back
	function automatic logic [7:0] to_asc(input logic [3:0] n);
		to_asc = (n < 4'hA) ? (8'h30 + {4'h0, n}) : (8'h37 + {4'h0, n});
	endfunction
	function automatic logic [3:0] from_asc(input logic [7:0] c);
		from_asc = (c >= 8'h41) ? 4'((c - 8'h37)) : 4'((c - 8'h30));
	endfunction

	// request edge detection on the control bits
	assign rx_edge = rx_ctrl_reg[rsfe_pkg::REQ_BIT] & ~rx_req_d_reg;
	assign tx_edge = tx_ctrl_reg[rsfe_pkg::REQ_BIT] & ~tx_req_d_reg;
	assign rx_ch_sel = rx_ctrl_reg[rsfe_pkg::CH_LSB +: 8];
	assign tx_ch_sel = tx_ctrl_reg[rsfe_pkg::CH_LSB +: 8];
	assign rx_lim = rx_fmt_reg[7:0];

	// receive byte source; ascii pairs fold into one byte, high digit first
	assign rx_in_valid = rx_job_ch_reg ? rx_valid_1 : rx_valid_0;
	assign rx_in_data  = rx_job_ch_reg ? rx_data_1 : rx_data_0;
	assign rx_byte_ok  = rx_in_valid & (~rx_job_asc_reg | rx_half_reg);
	assign rx_byte     = rx_job_asc_reg ? {rx_nib_reg, from_asc(rx_in_data)} : rx_in_data;
	assign rx_cnt_inc  = rx_cnt_reg + 9'h001;
	assign rx_fin = (rx_job_fmt_reg[15:8] == rsfe_pkg::FMT_COUNT)
		? (rx_cnt_inc == {1'b0, rx_job_fmt_reg[7:0]})
		: (rx_byte == rx_job_fmt_reg[7:0]);
	assign rx_ovf = ~rx_fin & (rx_cnt_inc >= rx_size_reg);

	// control and status of the receive job
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rx_state_reg   <= rsfe_pkg::RSFE_IDLE;
			rx_req_d_reg   <= 1'b0;
			rx_job_fmt_reg <= 16'h0000;
			rx_job_ch_reg  <= 1'b0;
			rx_job_asc_reg <= 1'b0;
			rx_done_reg    <= 1'b0;
			rx_err_reg     <= 1'b0;
			rx_code_reg    <= rsfe_pkg::ERR_NONE;
			rx_cnt_reg     <= 9'h000;
			rx_len_reg     <= 9'h000;
			rx_half_reg    <= 1'b0;
			rx_nib_reg     <= 4'h0;
		end else begin
			rx_req_d_reg <= rx_ctrl_reg[rsfe_pkg::REQ_BIT];
			case (rx_state_reg)
				rsfe_pkg::RSFE_IDLE: begin
					if (rx_edge && rx_ctrl_reg[rsfe_pkg::EN_BIT]) begin
						rx_done_reg    <= 1'b0;
						rx_err_reg     <= 1'b0;
						rx_code_reg    <= rsfe_pkg::ERR_NONE;
						rx_cnt_reg     <= 9'h000;
						rx_half_reg    <= 1'b0;
						rx_job_fmt_reg <= rx_fmt_reg; // fresh definition per command
						rx_job_ch_reg  <= rx_ch_sel[0];
						rx_job_asc_reg <= rx_ctrl_reg[rsfe_pkg::ASC_BIT];
						if (rx_ch_sel > rsfe_pkg::CH_MAX ||
							rx_fmt_reg[15:8] > rsfe_pkg::FMT_TERM) begin
							rx_err_reg  <= 1'b1;
							rx_code_reg <= rsfe_pkg::ERR_PARAM;
						end else if (rx_fmt_reg[15:8] == rsfe_pkg::FMT_COUNT &&
							(rx_lim == 8'h00 || {1'b0, rx_lim} > rx_size_reg)) begin
							rx_err_reg  <= 1'b1;
							rx_code_reg <= rsfe_pkg::ERR_NUMBER;
						end else begin
							rx_state_reg <= rsfe_pkg::RSFE_BUSY;
						end
					end
				end
				rsfe_pkg::RSFE_BUSY: begin
					if (!rx_ctrl_reg[rsfe_pkg::EN_BIT]) begin
						rx_state_reg <= rsfe_pkg::RSFE_IDLE; // abandon frame
					end else if (rx_in_valid && !rx_byte_ok) begin
						rx_half_reg <= 1'b1;
						rx_nib_reg  <= from_asc(rx_in_data);
					end else if (rx_byte_ok) begin
						rx_half_reg <= 1'b0;
						rx_cnt_reg  <= rx_cnt_inc;
						if (rx_fin) begin
							rx_done_reg  <= 1'b1;
							rx_len_reg   <= rx_cnt_inc;
							rx_state_reg <= rsfe_pkg::RSFE_IDLE;
						end else if (rx_ovf) begin
							rx_err_reg   <= 1'b1;
							rx_code_reg  <= rsfe_pkg::ERR_NUMBER;
							rx_len_reg   <= rx_cnt_inc;
							rx_state_reg <= rsfe_pkg::RSFE_IDLE;
						end
					end
				end
				default: rx_state_reg <= rsfe_pkg::RSFE_IDLE;
			endcase
		end
	end

	// receive buffer write, first byte at index zero
	always_ff @(posedge ref_clk) begin
		if (rx_state_reg == rsfe_pkg::RSFE_BUSY && rx_ctrl_reg[rsfe_pkg::EN_BIT] && rx_byte_ok) begin
			rx_mem[rx_cnt_reg[7:0]] <= rx_byte;
		end
	end

	// send character: raw byte, or two ascii digits high first
	assign tx_cur  = tx_mem[tx_idx_reg[7:0]];
	assign tx_char = tx_asc_reg ? to_asc(tx_half_reg ? tx_cur[3:0] : tx_cur[7:4]) : tx_cur;
	assign tx_take = tx_valid & tx_ready;
	assign tx_fin  = (tx_idx_reg == tx_last_reg) & (~tx_asc_reg | tx_half_reg);

	// send job; software has loaded buffer and length before the edge
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			tx_state_reg <= rsfe_pkg::RSFE_IDLE;
			tx_req_d_reg <= 1'b0;
			tx_done_reg  <= 1'b0;
			tx_err_reg   <= 1'b0;
			tx_code_reg  <= rsfe_pkg::ERR_NONE;
			tx_idx_reg   <= 9'h000;
			tx_half_reg  <= 1'b0;
			tx_asc_reg   <= 1'b0;
			tx_last_reg  <= 9'h000;
			tx_valid     <= 1'b0;
			tx_data      <= 8'h00;
			tx_chan      <= 1'b0;
		end else begin
			tx_req_d_reg <= tx_ctrl_reg[rsfe_pkg::REQ_BIT];
			case (tx_state_reg)
				rsfe_pkg::RSFE_IDLE: begin
					if (tx_edge) begin
						tx_done_reg <= 1'b0;
						tx_err_reg  <= 1'b0;
						tx_code_reg <= rsfe_pkg::ERR_NONE;
						tx_idx_reg  <= 9'h000;
						tx_half_reg <= 1'b0;
						tx_asc_reg  <= tx_ctrl_reg[rsfe_pkg::ASC_BIT];
						tx_chan     <= tx_ch_sel[0];
						tx_last_reg <= tx_len_reg[8:0] - 9'h001;
						if (tx_ch_sel > rsfe_pkg::CH_MAX) begin
							tx_err_reg  <= 1'b1;
							tx_code_reg <= rsfe_pkg::ERR_PARAM;
						end else if (tx_len_reg > rsfe_pkg::SEND_MAX) begin
							tx_err_reg  <= 1'b1;
							tx_code_reg <= rsfe_pkg::ERR_FRAME;
						end else if (tx_len_reg == 16'h0000 || tx_len_reg[8:0] > tx_size_reg) begin
							tx_err_reg  <= 1'b1;
							tx_code_reg <= rsfe_pkg::ERR_NUMBER;
						end else begin
							tx_state_reg <= rsfe_pkg::RSFE_BUSY;
						end
					end
				end
				rsfe_pkg::RSFE_BUSY: begin
					if (!tx_valid) begin
						tx_valid <= 1'b1;
						tx_data  <= tx_char;
					end else if (tx_take) begin
						tx_valid <= 1'b0;
						if (tx_fin) begin
							tx_done_reg  <= 1'b1;
							tx_idx_reg   <= tx_idx_reg + 9'h001; // status length counts every byte
							tx_state_reg <= rsfe_pkg::RSFE_IDLE;
						end else if (tx_asc_reg && !tx_half_reg) begin
							tx_half_reg <= 1'b1;
						end else begin
							tx_half_reg <= 1'b0;
							tx_idx_reg  <= tx_idx_reg + 9'h001;
						end
					end
				end
				default: tx_state_reg <= rsfe_pkg::RSFE_IDLE;
			endcase
		end
	end

	// software registers and send buffer writes
	assign wr_hit = bus_wr & (bus_addr[11:10] == 2'h0);
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			rx_ctrl_reg  <= 16'h0000;
			rx_fmt_reg   <= 16'h0000;
			tx_ctrl_reg  <= 16'h0000;
			tx_len_reg   <= 16'h0000;
			rx_size_reg  <= rsfe_pkg::SIZE_RST;
			tx_size_reg  <= rsfe_pkg::SIZE_RST;
			irq_mask_reg <= 4'h0;
		end else if (wr_hit) begin
			case (bus_addr)
				rsfe_pkg::RX_CTRL:   rx_ctrl_reg  <= bus_wdata[15:0];
				rsfe_pkg::RX_FORMAT: rx_fmt_reg   <= bus_wdata[15:0];
				rsfe_pkg::RX_SIZE:   rx_size_reg  <= bus_wdata[8:0];
				rsfe_pkg::TX_CTRL:   tx_ctrl_reg  <= bus_wdata[15:0];
				rsfe_pkg::TX_LENGTH: tx_len_reg   <= bus_wdata[15:0];
				rsfe_pkg::TX_SIZE:   tx_size_reg  <= bus_wdata[8:0];
				rsfe_pkg::IRQ_MASK:  irq_mask_reg <= bus_wdata[3:0];
				default: ;
			endcase
		end
	end
	always_ff @(posedge ref_clk) begin
		if (bus_wr && bus_addr[11:10] == rsfe_pkg::TXBUF_PAGE) begin
			tx_mem[bus_addr[9:2]] <= bus_wdata[7:0];
		end
	end

	// interrupt events: frame completions, and errors on a rising error flag
	always_comb begin
		ev                       = 4'h0;
		ev[rsfe_pkg::IRQ_RXDONE] = (rx_state_reg == rsfe_pkg::RSFE_BUSY) && rx_byte_ok && rx_fin
			&& rx_ctrl_reg[rsfe_pkg::EN_BIT];
		ev[rsfe_pkg::IRQ_RXERR]  = rx_err_reg & ~rx_err_d_reg;
		ev[rsfe_pkg::IRQ_TXDONE] = (tx_state_reg == rsfe_pkg::RSFE_BUSY) && tx_take && tx_fin;
		ev[rsfe_pkg::IRQ_TXERR]  = tx_err_reg & ~tx_err_d_reg;
	end
	// sticky status, set wins over write-one-to-clear; level interrupt one cycle later
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			irq_stat_reg <= 4'h0;
			rx_err_d_reg <= 1'b0;
			tx_err_d_reg <= 1'b0;
			irq          <= 1'b0;
		end else begin
			irq_stat_reg <= (irq_stat_reg & ~((bus_wr && bus_addr == rsfe_pkg::IRQ_STATUS)
				? bus_wdata[3:0] : 4'h0)) | ev;
			rx_err_d_reg <= rx_err_reg;
			tx_err_d_reg <= tx_err_reg;
			irq          <= |(irq_stat_reg & irq_mask_reg);
		end
	end
	// read port, data one cycle after the strobe; unmapped reads zero
	always_ff @(posedge ref_clk) begin
		if (srst) begin
			bus_rdata <= 32'h0000_0000;
		end else if (bus_rd) begin
			if (bus_addr[11:10] == rsfe_pkg::RXBUF_PAGE) begin
				bus_rdata <= {24'h00_0000, rx_mem[bus_addr[9:2]]};
			end else if (bus_addr[11:10] == rsfe_pkg::TXBUF_PAGE) begin
				bus_rdata <= {24'h00_0000, tx_mem[bus_addr[9:2]]};
			end else begin
				case (bus_addr)
					rsfe_pkg::RX_CTRL:    bus_rdata <= {16'h0000, rx_ctrl_reg};
					rsfe_pkg::RX_FORMAT:  bus_rdata <= {16'h0000, rx_fmt_reg};
					rsfe_pkg::RX_SIZE:    bus_rdata <= {23'h00_0000, rx_size_reg};
					rsfe_pkg::RX_STATUS:  bus_rdata <= {7'h00, rx_len_reg, rx_code_reg,
						6'h00, rx_err_reg, rx_done_reg};
					rsfe_pkg::TX_CTRL:    bus_rdata <= {16'h0000, tx_ctrl_reg};
					rsfe_pkg::TX_LENGTH:  bus_rdata <= {16'h0000, tx_len_reg};
					rsfe_pkg::TX_SIZE:    bus_rdata <= {23'h00_0000, tx_size_reg};
					rsfe_pkg::TX_STATUS:  bus_rdata <= {7'h00, tx_idx_reg, tx_code_reg,
						6'h00, tx_err_reg, tx_done_reg};
					rsfe_pkg::IRQ_STATUS: bus_rdata <= {28'h000_0000, irq_stat_reg};
					rsfe_pkg::IRQ_MASK:   bus_rdata <= {28'h000_0000, irq_mask_reg};
					default:              bus_rdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// checks
	property p_rx_start_edge;
		(rx_state_reg == rsfe_pkg::RSFE_IDLE ##1 rx_state_reg == rsfe_pkg::RSFE_BUSY)
		|-> $past(rx_edge);
	endproperty
	a_rx_start_edge: assert property (p_rx_start_edge) else $error("receive began without edge");
	property p_rx_chan;
		(rx_state_reg == rsfe_pkg::RSFE_IDLE && rx_edge && rx_ctrl_reg[rsfe_pkg::EN_BIT]
		&& rx_ch_sel > rsfe_pkg::CH_MAX) |=> rx_err_reg && rx_code_reg == rsfe_pkg::ERR_PARAM
		&& rx_state_reg == rsfe_pkg::RSFE_IDLE;
	endproperty
	a_rx_chan: assert property (p_rx_chan) else $error("bad receive channel accepted");
	property p_rx_count;
		$rose(rx_done_reg) && rx_job_fmt_reg[15:8] == rsfe_pkg::FMT_COUNT
		|-> rx_len_reg == {1'b0, rx_job_fmt_reg[7:0]};
	endproperty
	a_rx_count: assert property (p_rx_count) else $error("count frame length wrong");
	property p_rx_term;
		$rose(rx_done_reg) && rx_job_fmt_reg[15:8] == rsfe_pkg::FMT_TERM
		|-> rx_mem[8'(rx_len_reg - 9'h001)] == rx_job_fmt_reg[7:0];
	endproperty
	a_rx_term: assert property (p_rx_term) else $error("frame not ended on terminator");
	property p_rx_enable;
		!rx_ctrl_reg[rsfe_pkg::EN_BIT] |=> !$rose(rx_done_reg);
	endproperty
	a_rx_enable: assert property (p_rx_enable) else $error("frame done while disabled");
	property p_tx_frame;
		(tx_state_reg == rsfe_pkg::RSFE_IDLE && tx_edge && tx_ch_sel <= rsfe_pkg::CH_MAX
		&& tx_len_reg > rsfe_pkg::SEND_MAX) |=> tx_err_reg && tx_code_reg == rsfe_pkg::ERR_FRAME;
	endproperty
	a_tx_frame: assert property (p_tx_frame) else $error("long send not refused");
	property p_tx_clear;
		(tx_state_reg == rsfe_pkg::RSFE_IDLE && tx_edge && tx_ch_sel <= rsfe_pkg::CH_MAX
		&& tx_len_reg == 16'h0001 && tx_size_reg != 9'h000)
		|=> !tx_done_reg && !tx_err_reg && tx_state_reg == rsfe_pkg::RSFE_BUSY;
	endproperty
	a_tx_clear: assert property (p_tx_clear) else $error("flags not cleared on start");
	property p_tx_stable;
		tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
	endproperty
	a_tx_stable: assert property (p_tx_stable) else $error("send byte dropped");
	property p_irq;
		|(irq_stat_reg & irq_mask_reg) |=> irq;
	endproperty
	a_irq: assert property (p_irq) else $error("interrupt missing");
endmodule

/* rtl/rsfe_pkg.sv */
// package: register map, field layout, codes and limits of the raw serial frame engine
package rsfe_pkg;
	localparam int          AW          = 12;
	localparam int          DW          = 32;
	localparam int          DEPTH       = 256;
	localparam int          IW          = 8;
	localparam int          LW          = 9;
	localparam int          MAX_FRAMES  = 128;
	// register offsets
	localparam logic [11:0] RX_CTRL     = 12'h000;
	localparam logic [11:0] RX_FORMAT   = 12'h004;
	localparam logic [11:0] RX_STATUS   = 12'h008;
	localparam logic [11:0] RX_SIZE     = 12'h00C;
	localparam logic [11:0] TX_CTRL     = 12'h010;
	localparam logic [11:0] TX_LENGTH   = 12'h014;
	localparam logic [11:0] TX_STATUS   = 12'h018;
	localparam logic [11:0] TX_SIZE     = 12'h01C;
	localparam logic [11:0] IRQ_STATUS  = 12'h020;
	localparam logic [11:0] IRQ_MASK    = 12'h024;
	localparam logic [1:0]  RXBUF_PAGE  = 2'h1;
	localparam logic [1:0]  TXBUF_PAGE  = 2'h2;
	// control and status field positions
	localparam int          REQ_BIT     = 0;
	localparam int          EN_BIT      = 1;
	localparam int          ASC_BIT     = 2;
	localparam int          CH_LSB      = 8;
	localparam int          ST_ERR_BIT  = 1;
	localparam int          ST_CODE_LSB = 8;
	localparam int          ST_LEN_LSB  = 16;
	// format modes, codes and limits
	localparam logic [7:0]  FMT_COUNT   = 8'h00;
	localparam logic [7:0]  FMT_TERM    = 8'h01;
	localparam logic [7:0]  CH_MAX      = 8'h01;
	localparam logic [7:0]  ERR_NONE    = 8'h00;
	localparam logic [7:0]  ERR_PARAM   = 8'h06;
	localparam logic [7:0]  ERR_NUMBER  = 8'h08;
	localparam logic [7:0]  ERR_FRAME   = 8'h09;
	localparam logic [15:0] SEND_MAX    = 16'h00FF;
	localparam logic [8:0]  SIZE_RST    = 9'h100;
	// interrupt bits
	localparam int          IRQ_RXDONE  = 0;
	localparam int          IRQ_RXERR   = 1;
	localparam int          IRQ_TXDONE  = 2;
	localparam int          IRQ_TXERR   = 3;
	localparam int          IRQ_N       = 4;
	typedef enum logic {RSFE_IDLE, RSFE_BUSY} rsfe_state_e;
endpackage

/* testbench/rsfe_instr.sv */
// serial instrument model: sends bytes to the engine and collects what it sends
`timescale 1ns/1ps
module rsfe_instr (
	input  wire logic       ref_clk,
	input  wire logic       tx_valid,
	input  wire logic [7:0] tx_data,
	input  wire logic       tx_chan,
	output logic            tx_ready,
	output logic            rx_valid_0,
	output logic [7:0]      rx_data_0,
	output logic            rx_valid_1,
	output logic [7:0]      rx_data_1
);
	logic [8:0] got_q[$];
	logic       slow;
	// idle levels at time zero
	initial begin
		tx_ready = 1'b0;
		slow = 1'b0;
		rx_valid_0 = 1'b0;
		rx_valid_1 = 1'b0;
		rx_data_0 = 8'hA5;
		rx_data_1 = 8'h5A;
	end
	// one byte pulse on channel 0 or 1; idle data shows the inverse afterwards
	task automatic put_byte(input logic ch, input logic [7:0] b);
		@(posedge ref_clk);
		if (ch) begin
			rx_valid_1 <= 1'b1;
			rx_data_1 <= b;
		end else begin
			rx_valid_0 <= 1'b1;
			rx_data_0 <= b;
		end
		@(posedge ref_clk);
		rx_valid_0 <= 1'b0;
		rx_valid_1 <= 1'b0;
		if (ch) rx_data_1 <= ~b;
		else rx_data_0 <= ~b;
	endtask
	// take sent bytes, stalling at random while slow is set
	always @(posedge ref_clk) begin
		if (tx_valid && tx_ready) got_q.push_back({tx_chan, tx_data});
		tx_ready <= slow ? 1'(($urandom & 3) == 0) : 1'b1;
	end
endmodule

/* testbench/tb_rsfe_top.sv */
// self-checking testbench of the raw serial frame engine
`timescale 1ns/1ps
module tb_rsfe_top;
	logic        ref_clk;
	logic        srst;
	logic [11:0] bus_addr;
	logic [31:0] bus_wdata;
	logic [31:0] bus_rdata;
	logic        bus_wr;
	logic        bus_rd;
	logic        irq;
	logic        rx_valid_0;
	logic        rx_valid_1;
	logic [7:0]  rx_data_0;
	logic [7:0]  rx_data_1;
	logic        tx_valid;
	logic        tx_chan;
	logic        tx_ready;
	logic [7:0]  tx_data;
	int          fail_count;
	int          num_checks;
	int          cyc;
	logic [31:0] rd;
	logic [8:0]  eq[$];

	rsfe_top rsfe_top_i (.ref_clk(ref_clk), .srst(srst), .bus_addr(bus_addr),
		.bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd), .bus_rdata(bus_rdata),
		.irq(irq), .rx_valid_0(rx_valid_0), .rx_data_0(rx_data_0), .rx_valid_1(rx_valid_1),
		.rx_data_1(rx_data_1), .tx_valid(tx_valid), .tx_data(tx_data), .tx_chan(tx_chan),
		.tx_ready(tx_ready));
	rsfe_instr rsfe_instr_i (.ref_clk(ref_clk), .tx_valid(tx_valid), .tx_data(tx_data),
		.tx_chan(tx_chan), .tx_ready(tx_ready), .rx_valid_0(rx_valid_0),
		.rx_data_0(rx_data_0), .rx_valid_1(rx_valid_1), .rx_data_1(rx_data_1));

	// 10 MHz clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	// compare and count
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// verdict and end of run
	task automatic end_sim();
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// hang guard
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 60000) begin
			fail_count++;
			end_sim();
		end
	end
	// register bus cycles
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		bus_wr <= 1'b1;
		bus_addr <= a;
		bus_wdata <= d;
		@(posedge ref_clk);
		bus_wr <= 1'b0;
	endtask
	task automatic rdr(input logic [11:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		bus_rd <= 1'b1;
		bus_addr <= a;
		@(posedge ref_clk);
		bus_rd <= 1'b0;
		#1 d = bus_rdata;
	endtask
	// poll a status word until done or error shows
	task automatic wait_done(input logic [11:0] a);
		for (int i = 0; i < 300; i++) begin
			rdr(a, rd);
			if (rd[1:0] !== 2'b00) break;
		end
	endtask
	// expected status: done with length, or error with code
	task automatic chk_st(input logic [11:0] a, input logic [7:0] code, input int len);
		rdr(a, rd);
		if (code == rsfe_pkg::ERR_NONE) check(rd & 32'h01FFFF03, {7'h00, 9'(len), 16'h0001});
		else check(rd & 32'h0000FF03, {16'h0000, code, 8'h02});
	endtask
	// receive job: drop request, set format, raise request with enable
	task automatic rx_job(input logic [7:0] ch, input logic [15:0] fmt);
		wr(rsfe_pkg::RX_CTRL, {16'h0000, ch, 8'h02});
		wr(rsfe_pkg::RX_FORMAT, {16'h0000, fmt});
		wr(rsfe_pkg::RX_CTRL, {16'h0000, ch, 8'h03});
		repeat (3) @(posedge ref_clk);
	endtask
	// read back the receive buffer against the expected bytes
	task automatic chk_rxbuf();
		for (int i = 0; i < eq.size(); i++) begin
			rdr(12'h400 + 12'(4 * i), rd);
			check(rd, {24'h000000, eq[i][7:0]});
		end
	endtask
	// send job after the buffer was loaded
	task automatic tx_job(input logic [7:0] ch, input logic [15:0] len, input logic asc);
		wr(rsfe_pkg::TX_CTRL, 32'h00000000);
		wr(rsfe_pkg::TX_LENGTH, {16'h0000, len});
		wr(rsfe_pkg::TX_CTRL, {16'h0000, ch, 5'h00, asc, 2'b01});
		wait_done(rsfe_pkg::TX_STATUS);
	endtask
	// compare what the instrument collected
	task automatic chk_got();
		check(32'(rsfe_instr_i.got_q.size()), 32'(eq.size()));
		for (int i = 0; i < eq.size() && i < rsfe_instr_i.got_q.size(); i++)
			check({23'h0, rsfe_instr_i.got_q[i]}, {23'h0, eq[i]});
		rsfe_instr_i.got_q.delete();
		eq.delete();
	endtask

	// main sequence
	initial begin
		logic [7:0]  b;
		logic        c;
		int          n;
		logic [31:0] errs[4];
		srst = 1'b1;
		bus_addr = 12'h000;
		bus_wdata = 32'h00000000;
		bus_wr = 1'b0;
		bus_rd = 1'b0;
		n = $urandom(81150);
		repeat (16) @(posedge ref_clk);
		srst <= 1'b0;
		wr(rsfe_pkg::IRQ_MASK, 32'h00000000);
		// count mode on both channels, lengths 1, random and 255
		for (int k = 0; k < 4; k++) begin
			c = k[0];
			n = (k == 0) ? 1 : (k == 3) ? 255 : 2 + int'($urandom % 7);
			rx_job({7'h00, c}, {8'h00, 8'(n)});
			rsfe_instr_i.put_byte(~c, 8'hEE);
			for (int i = 0; i < n; i++) begin
				b = 8'($urandom);
				eq.push_back({1'b0, b});
				rsfe_instr_i.put_byte(c, b);
				if (i == n - 2) rdr(rsfe_pkg::RX_STATUS, rd);
				if (i == n - 2) check({31'h0, rd[0]}, 32'h0);
			end
			wait_done(rsfe_pkg::RX_STATUS);
			chk_st(rsfe_pkg::RX_STATUS, rsfe_pkg::ERR_NONE, n);
			chk_rxbuf();
			eq.delete();
		end
		$display("test count_mode finished");
		// terminator mode, bytes after the terminator are not kept
		rx_job(8'h01, 16'h0104);
		rdr(rsfe_pkg::RX_STATUS, rd);
		check(rd & 32'h0000FF03, 32'h0);
		n = 2 + int'($urandom % 6);
		for (int i = 0; i <= n; i++) begin
			b = (i == n) ? 8'h04 : 8'($urandom);
			if (i < n && b == 8'h04) b = 8'h05;
			eq.push_back({1'b0, b});
			rsfe_instr_i.put_byte(1'b1, b);
		end
		rsfe_instr_i.put_byte(1'b1, 8'h33);
		wait_done(rsfe_pkg::RX_STATUS);
		chk_st(rsfe_pkg::RX_STATUS, rsfe_pkg::ERR_NONE, n + 1);
		chk_rxbuf();
		// request held high, then request without enable: no new job
		wr(rsfe_pkg::RX_CTRL, 32'h00000103);
		rsfe_instr_i.put_byte(1'b1, 8'h04);
		wr(rsfe_pkg::RX_CTRL, 32'h00000100);
		wr(rsfe_pkg::RX_CTRL, 32'h00000101);
		rsfe_instr_i.put_byte(1'b1, 8'h04);
		repeat (3) @(posedge ref_clk);
		chk_st(rsfe_pkg::RX_STATUS, rsfe_pkg::ERR_NONE, n + 1);
		chk_rxbuf();
		eq.delete();
		$display("test terminator_mode finished");
		// ascii receive: four characters fold into two bytes, high digit first
		wr(rsfe_pkg::RX_CTRL, 32'h00000006);
		wr(rsfe_pkg::RX_FORMAT, 32'h00000002);
		wr(rsfe_pkg::RX_CTRL, 32'h00000007);
		eq = '{9'h01A, 9'h0B3};
		rsfe_instr_i.put_byte(1'b0, 8'h31);
		rsfe_instr_i.put_byte(1'b0, 8'h41);
		rsfe_instr_i.put_byte(1'b0, 8'h42);
		rsfe_instr_i.put_byte(1'b0, 8'h33);
		wait_done(rsfe_pkg::RX_STATUS);
		chk_st(rsfe_pkg::RX_STATUS, rsfe_pkg::ERR_NONE, 2);
		chk_rxbuf();
		eq.delete();
		$display("test ascii_receive finished");
		// bad channel and bad format upper byte
		rx_job(8'h02, 16'h0002);
		wait_done(rsfe_pkg::RX_STATUS);
		chk_st(rsfe_pkg::RX_STATUS, rsfe_pkg::ERR_PARAM, 0);
		rx_job(8'h00, 16'h0202);
		wait_done(rsfe_pkg::RX_STATUS);
		chk_st(rsfe_pkg::RX_STATUS, rsfe_pkg::ERR_PARAM, 0);
		// interrupt: sticky, masked, unmasked, cleared
		rdr(rsfe_pkg::IRQ_STATUS, rd);
		check(rd & 32'hF, 32'h3);
		check({31'h0, irq}, 32'h0);
		wr(rsfe_pkg::IRQ_MASK, 32'h0000000F);
		repeat (2) @(posedge ref_clk);
		check({31'h0, irq}, 32'h1);
		wr(rsfe_pkg::IRQ_STATUS, 32'h0000000F);
		repeat (2) @(posedge ref_clk);
		check({31'h0, irq}, 32'h0);
		rdr(12'h0FC, rd);
		check(rd, 32'h0);
		$display("test irq_and_errors finished");
		// sends with random stalls, then 255 bytes at full speed
		for (int k = 0; k < 3; k++) begin
			c = 1'($urandom);
			n = (k == 2) ? 255 : (k == 0) ? 1 : 2 + int'($urandom % 7);
			rsfe_instr_i.slow = (k != 2);
			for (int i = 0; i < n; i++) begin
				b = 8'($urandom);
				eq.push_back({c, b});
				wr(12'h800 + 12'(4 * i), {24'h0, b});
			end
			tx_job({7'h00, c}, 16'(n), 1'b0);
			chk_st(rsfe_pkg::TX_STATUS, rsfe_pkg::ERR_NONE, n);
			chk_got();
		end
		// ascii send: each nibble as an upper-case character
		wr(12'h800, 32'h0000001A);
		wr(12'h804, 32'h000000B3);
		eq = '{9'h031, 9'h041, 9'h042, 9'h033};
		tx_job(8'h00, 16'h0002, 1'b1);
		chk_st(rsfe_pkg::TX_STATUS, rsfe_pkg::ERR_NONE, 2);
		chk_got();
		// send refusals: length, channel and buffer size
		errs = '{{16'd256, 8'h00, rsfe_pkg::ERR_FRAME}, {16'd0, 8'h00, rsfe_pkg::ERR_NUMBER},
			{16'd1, 8'h02, rsfe_pkg::ERR_PARAM}, {16'd5, 8'h00, rsfe_pkg::ERR_NUMBER}};
		for (int k = 0; k < 4; k++) begin
			if (k == 3) wr(rsfe_pkg::TX_SIZE, 32'h00000004);
			tx_job(errs[k][15:8], errs[k][31:16], 1'b0);
			chk_st(rsfe_pkg::TX_STATUS, errs[k][7:0], 0);
			chk_got();
		end
		$display("test send finished");
		end_sim();
	end
endmodule
